// [src/ppicr_regs.v]
// Purpose: Per-port interrupt and configuration registers on AHB-Lite
// Assumes: One clock mclk_in, synchronous active-high reset_in
// Notes: Zero-wait slave; unmapped reads give zero, writes are dropped
// Notes on behaviour
// R1: Test and line interrupt need global enable
// R2: Enabled test interrupt: pin low, pending set
// R3: Test interrupt plus line enable pulses management line
// R4: Pending clears after status read then interrupt read
// R5: Line interrupt enable bit, resets to zero
// R6: Transmit test sends regardless of receive state
// R7: Loopback bit one returns only carrier sense
// R8: SQE bit one enables SQE, resets zero
// R9: Jabber bit one disables jabber, resets zero
// R10: Link test bit one disables integrity test
// R11: Link test resets zero if autoneg, else strap
// R12: Bypass bit skips scrambler and descrambler
// R13: Bypass bit resets to its strap level
// R14: Fiber bit one fiber, zero twisted pair
// R15: Fiber bit resets zero when strap low
// R16: Twisted-pair-only ports ignore fiber bit
// R17: Controller writes reserved as zero, ignores reads
// R18: Interrupt pin low while pending flag set
`timescale 1ns/100ps
`include "ppicr_map.vh"
module ppicr_regs #(
  parameter TP_ONLY_PORT = 0,
  parameter MDIO_PULSE_CYCLES = 1
) (
  input wire mclk_in,
  input wire reset_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  input wire [15:0] basic_status_in,
  input wire port_event_in,
  input wire autoneg_enable_pin_in,
  input wire link_test_strap_pin_in,
  input wire scrambler_bypass_strap_pin_in,
  input wire fiber_select_strap_pin_in,
  output reg interrupt_output_n_out,
  output wire mdio_interrupt_pulse_out,
  output reg tx_test_enable_out,
  output reg loopback_data_disable_out,
  output reg sqe_enable_out,
  output reg jabber_disable_out,
  output reg link_test_disable_out,
  output reg scrambler_bypass_out,
  output reg fiber_select_out
);

  // Index of a word address, and whether it falls in the 32-word map
  function [`PPICR_IDX_W-1:0] ppicr_index;
    input [31:0] addr;
    begin
      ppicr_index = addr[`PPICR_ADDR_IDX_MSB:`PPICR_ADDR_IDX_LSB];
    end
  endfunction

  function ppicr_in_map;
    input [31:0] addr;
    begin
      ppicr_in_map = (addr[31:`PPICR_ADDR_HIGH_LSB] == 25'h0000000);
    end
  endfunction

  // Strap levels through the three-stage chain
  wire [`PPICR_STRAP_W-1:0] strap_level;
  wire [`PPICR_STRAP_W-1:0] strap_raw;
  assign strap_raw = {fiber_select_strap_pin_in,
                      scrambler_bypass_strap_pin_in,
                      link_test_strap_pin_in,
                      autoneg_enable_pin_in};

  ppicr_sync3 #(
    .WIDTH(`PPICR_STRAP_W)
  ) u_strap_sync (
    .mclk_in(mclk_in),
    .level_in(strap_raw),
    .level_out(strap_level)
  );

  // Bus address phase capture
  reg wr_pending_reg;
  reg [`PPICR_IDX_W-1:0] wr_index_reg;
  reg wr_in_map_reg;
  wire access_req;
  wire read_req;
  wire write_req;
  wire [`PPICR_IDX_W-1:0] req_index;
  wire req_in_map;

  // Only single word transfers are issued; hsize is accepted as a word
  assign access_req = hsel_in & hready_in &
                      (htrans_in == `PPICR_HTRANS_NONSEQ);
  assign read_req = access_req & ~hwrite_in;
  assign write_req = access_req & hwrite_in;
  assign req_index = ppicr_index(haddr_in);
  assign req_in_map = ppicr_in_map(haddr_in);

  always @(posedge mclk_in) begin
    if (reset_in) begin
      wr_pending_reg <= 1'b0;
      wr_index_reg <= {`PPICR_IDX_W{1'b0}};
      wr_in_map_reg <= 1'b0;
    end else begin
      wr_pending_reg <= write_req;
      if (write_req) begin
        wr_index_reg <= req_index;
        wr_in_map_reg <= req_in_map;
      end
    end
  end

  // Write strobes of the data phase
  wire wr_int_enable;
  wire wr_port_cfg;
  assign wr_int_enable = wr_pending_reg & wr_in_map_reg &
                         (wr_index_reg == `PPICR_IDX_INT_ENABLE);
  assign wr_port_cfg = wr_pending_reg & wr_in_map_reg &
                       (wr_index_reg == `PPICR_IDX_PORT_CFG);

  // Read strobes of the address phase
  wire rd_basic_status;
  wire rd_int_status;
  assign rd_basic_status = read_req & req_in_map &
                           (req_index == `PPICR_IDX_BASIC_STATUS);
  assign rd_int_status = read_req & req_in_map &
                         (req_index == `PPICR_IDX_INT_STATUS);

  // Interrupt enable register
  reg global_enable_reg;
  reg global_enable_next;
  reg test_force_reg;
  reg test_force_next;

  // Reserved bits are not stored, so stray writes there do nothing
  always @* begin
    global_enable_next = global_enable_reg;
    test_force_next = test_force_reg;
    if (wr_int_enable) begin
      global_enable_next = hwdata_in[`PPICR_IE_GLOBAL];
      test_force_next = hwdata_in[`PPICR_IE_TEST];
    end
  end

  // Port configuration register
  reg tx_test_reg;
  reg tx_test_next;
  reg mdio_int_reg;
  reg mdio_int_next;
  reg loop_dis_reg;
  reg loop_dis_next;
  reg sqe_reg;
  reg sqe_next;
  reg jabber_dis_reg;
  reg jabber_dis_next;
  reg link_dis_reg;
  reg link_dis_next;
  reg scr_bypass_reg;
  reg scr_bypass_next;
  reg fiber_reg;
  reg fiber_next;
  reg strap_load_reg;
  reg strap_wait_reg;

  always @* begin
    tx_test_next = tx_test_reg;
    mdio_int_next = mdio_int_reg;
    loop_dis_next = loop_dis_reg;
    sqe_next = sqe_reg;
    jabber_dis_next = jabber_dis_reg;
    link_dis_next = link_dis_reg;
    scr_bypass_next = scr_bypass_reg;
    fiber_next = fiber_reg;
    if (strap_load_reg) begin
      link_dis_next = strap_level[`PPICR_STRAP_AUTONEG] ? 1'b0 :
                      strap_level[`PPICR_STRAP_LINK]; // R11
      scr_bypass_next = strap_level[`PPICR_STRAP_SCR]; // R13
      fiber_next = strap_level[`PPICR_STRAP_FIBER]; // R15
    end
    if (wr_port_cfg) begin
      tx_test_next = hwdata_in[`PPICR_PC_TX_TEST];
      mdio_int_next = hwdata_in[`PPICR_PC_MDIO_INT]; // R5
      loop_dis_next = hwdata_in[`PPICR_PC_LOOP_DIS];
      sqe_next = hwdata_in[`PPICR_PC_SQE];
      jabber_dis_next = hwdata_in[`PPICR_PC_JABBER_DIS];
      link_dis_next = hwdata_in[`PPICR_PC_LINK_DIS];
      scr_bypass_next = hwdata_in[`PPICR_PC_SCR_BYPASS];
      fiber_next = hwdata_in[`PPICR_PC_FIBER];
    end
  end

  // Straps are caught on the second edge after release: a three-edge
  // reset leaves the synchroniser output settled only one edge later
  always @(posedge mclk_in) begin
    if (reset_in) begin
      global_enable_reg <= `PPICR_RST_BIT;
      test_force_reg <= `PPICR_RST_BIT;
      tx_test_reg <= `PPICR_RST_BIT;
      mdio_int_reg <= `PPICR_RST_BIT;
      loop_dis_reg <= `PPICR_RST_BIT;
      sqe_reg <= `PPICR_RST_BIT;
      jabber_dis_reg <= `PPICR_RST_BIT;
      link_dis_reg <= `PPICR_RST_BIT;
      scr_bypass_reg <= `PPICR_RST_BIT;
      fiber_reg <= `PPICR_RST_BIT;
      strap_load_reg <= 1'b0;
      strap_wait_reg <= 1'b1;
    end else begin
      global_enable_reg <= global_enable_next;
      test_force_reg <= test_force_next;
      tx_test_reg <= tx_test_next;
      mdio_int_reg <= mdio_int_next;
      loop_dis_reg <= loop_dis_next;
      sqe_reg <= sqe_next;
      jabber_dis_reg <= jabber_dis_next;
      link_dis_reg <= link_dis_next;
      scr_bypass_reg <= scr_bypass_next;
      fiber_reg <= fiber_next;
      strap_load_reg <= strap_wait_reg;
      strap_wait_reg <= 1'b0;
    end
  end

  // Interrupt pending flag and its two-read clear sequence
  reg pending_reg;
  reg clear_armed_reg;
  wire test_effective;
  wire mdio_effective;
  wire pending_set;
  wire pending_clear;

  assign test_effective = global_enable_reg & test_force_reg; // R1
  assign mdio_effective = global_enable_reg & mdio_int_reg; // R1
  assign pending_set = test_effective |
                       (global_enable_reg & port_event_in); // R2
  assign pending_clear = rd_int_status & clear_armed_reg; // R4

  always @(posedge mclk_in) begin
    if (reset_in) begin
      pending_reg <= 1'b0;
      clear_armed_reg <= 1'b0;
    end else begin
      // A set in the clearing cycle wins so no event is lost
      if (pending_set) begin
        pending_reg <= 1'b1; // R2
      end else if (pending_clear) begin
        pending_reg <= 1'b0; // R4
      end
      if (rd_basic_status) begin
        clear_armed_reg <= 1'b1; // R4
      end else if (rd_int_status) begin
        clear_armed_reg <= 1'b0;
      end
    end
  end

  // Line interrupt pulse when the flag newly rises
  wire mdio_trigger;
  assign mdio_trigger = mdio_effective & pending_set &
                        ~pending_reg; // R3

  ppicr_pulse #(
    .CYCLES(MDIO_PULSE_CYCLES),
    .CNT_W(4)
  ) u_mdio_pulse (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .trigger_in(mdio_trigger),
    .pulse_out(mdio_interrupt_pulse_out)
  );

  // Registered outputs toward the port logic
  always @(posedge mclk_in) begin
    if (reset_in) begin
      interrupt_output_n_out <= 1'b1;
      tx_test_enable_out <= 1'b0;
      loopback_data_disable_out <= 1'b0;
      sqe_enable_out <= 1'b0;
      jabber_disable_out <= 1'b0;
      link_test_disable_out <= 1'b0;
      scrambler_bypass_out <= 1'b0;
      fiber_select_out <= 1'b0;
    end else begin
      interrupt_output_n_out <= ~pending_reg; // R18
      tx_test_enable_out <= tx_test_reg; // R6
      loopback_data_disable_out <= loop_dis_reg; // R7
      sqe_enable_out <= sqe_reg; // R8
      jabber_disable_out <= jabber_dis_reg; // R9
      link_test_disable_out <= link_dis_reg; // R10
      scrambler_bypass_out <= scr_bypass_reg; // R12
      // Twisted-pair-only ports never select the fiber path
      fiber_select_out <= (TP_ONLY_PORT != 0) ? 1'b0 : fiber_reg; // R14 R16
    end
  end

  // Read data, built from next values so a read right after a write
  // to the same word sees the new contents
  reg [15:0] read_half;

  always @* begin
    read_half = `PPICR_RST_HALF;
    case (req_index)
      `PPICR_IDX_BASIC_STATUS: begin
        read_half = basic_status_in;
      end
      `PPICR_IDX_INT_ENABLE: begin
        read_half[`PPICR_IE_GLOBAL] = global_enable_next;
        read_half[`PPICR_IE_TEST] = test_force_next;
      end
      `PPICR_IDX_INT_STATUS: begin
        read_half[`PPICR_IS_PENDING] = pending_reg;
      end
      `PPICR_IDX_PORT_CFG: begin
        read_half[`PPICR_PC_TX_TEST] = tx_test_next;
        read_half[`PPICR_PC_MDIO_INT] = mdio_int_next;
        read_half[`PPICR_PC_LOOP_DIS] = loop_dis_next;
        read_half[`PPICR_PC_SQE] = sqe_next;
        read_half[`PPICR_PC_JABBER_DIS] = jabber_dis_next;
        read_half[`PPICR_PC_LINK_DIS] = link_dis_next;
        read_half[`PPICR_PC_SCR_BYPASS] = scr_bypass_next;
        read_half[`PPICR_PC_FIBER] = fiber_next;
      end
      default: begin
        read_half = `PPICR_RST_HALF;
      end
    endcase
    if (!req_in_map) begin
      read_half = `PPICR_RST_HALF;
    end
  end

  // Zero-wait responder: always ready and always OKAY
  always @(posedge mclk_in) begin
    if (reset_in) begin
      hrdata_out <= `PPICR_RST_WORD;
      hreadyout_out <= 1'b1;
      hresp_out <= `PPICR_HRESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= `PPICR_HRESP_OKAY;
      if (read_req) begin
        hrdata_out <= {16'h0000, read_half};
      end
    end
  end

endmodule // ppicr_regs

// [common/ppicr_map.vh]
// Purpose: Register map and field layout of the port management registers
// Assumes: Register index times four gives the AHB byte address
// Notes: Definitions only
`ifndef PPICR_MAP_VH
`define PPICR_MAP_VH

// Register indices (byte address = index * 4)
`define PPICR_IDX_W 5
`define PPICR_IDX_BASIC_STATUS 5'h01
`define PPICR_IDX_INT_ENABLE 5'h11
`define PPICR_IDX_INT_STATUS 5'h12
`define PPICR_IDX_PORT_CFG 5'h13
`define PPICR_ADDR_IDX_LSB 2
`define PPICR_ADDR_IDX_MSB 6
`define PPICR_ADDR_HIGH_LSB 7

// Interrupt enable fields
`define PPICR_IE_GLOBAL 1
`define PPICR_IE_TEST 0

// Interrupt status fields
`define PPICR_IS_PENDING 15

// Port configuration fields
`define PPICR_PC_TX_TEST 14
`define PPICR_PC_MDIO_INT 12
`define PPICR_PC_LOOP_DIS 11
`define PPICR_PC_SQE 10
`define PPICR_PC_JABBER_DIS 9
`define PPICR_PC_LINK_DIS 8
`define PPICR_PC_SCR_BYPASS 3
`define PPICR_PC_FIBER 2

// Reset values of software-only bits
`define PPICR_RST_BIT 1'h0
`define PPICR_RST_HALF 16'h0000
`define PPICR_RST_WORD 32'h0000_0000

// AHB-Lite encodings
`define PPICR_HTRANS_NONSEQ 2'h2
`define PPICR_HRESP_OKAY 1'h0

// Strap vector positions after the synchroniser
`define PPICR_STRAP_AUTONEG 0
`define PPICR_STRAP_LINK 1
`define PPICR_STRAP_SCR 2
`define PPICR_STRAP_FIBER 3
`define PPICR_STRAP_W 4

`endif

// [src/ppicr_sync3.v]
// Purpose: Three-stage synchroniser for slow pin levels
// Assumes: Inputs are quasi-static straps or levels from outside the clock
// Notes: A change is taken once stages two and three agree
`timescale 1ns/100ps
module ppicr_sync3 #(
  parameter WIDTH = 4
) (
  input wire mclk_in,
  input wire [WIDTH-1:0] level_in,
  output reg [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  integer i;

  // No reset: the chain keeps filling while reset is held, so the
  // straps are valid one edge after release if reset lasts three edges
  always @(posedge mclk_in) begin
    stage1_reg <= level_in;
    stage2_reg <= stage1_reg;
    stage3_reg <= stage2_reg;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (stage2_reg[i] == stage3_reg[i]) begin
        level_out[i] <= stage3_reg[i];
      end
    end
  end
endmodule // ppicr_sync3

// [src/ppicr_pulse.v]
// Purpose: Stretches a one-cycle trigger into a fixed-width pulse
// Assumes: Trigger comes from logic on the same clock
// Notes: A trigger during a pulse restarts it
`timescale 1ns/100ps
module ppicr_pulse #(
  parameter CYCLES = 1,
  parameter CNT_W = 4
) (
  input wire mclk_in,
  input wire reset_in,
  input wire trigger_in,
  output reg pulse_out
);
  reg [CNT_W-1:0] count_reg;

  always @(posedge mclk_in) begin
    if (reset_in) begin
      count_reg <= {CNT_W{1'b0}};
      pulse_out <= 1'b0;
    end else if (trigger_in) begin
      count_reg <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
      pulse_out <= 1'b1;
    end else if (count_reg != {CNT_W{1'b0}}) begin
      count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      pulse_out <= 1'b0;
    end
  end
endmodule // ppicr_pulse

// [testbench/ppicr_mac_model.sv]
// Purpose: Station management controller model, AHB-Lite master side
// Assumes: One outstanding single word transfer at a time
// Notes: Write data is inverted outside its data phase
`timescale 1ns/100ps
module ppicr_mac_model (
  input wire mclk_in,
  input wire hready_in,
  input wire [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'hffff_ffff;
  end

  // Callers other than t_ro keep reserved bits zero; the bench expects them zero on read
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
    @(posedge mclk_in);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    hwdata_out <= ~d;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
    hsel_out <= 1'b0;
    hwdata_out <= ~d;
  endtask
endmodule // ppicr_mac_model

// [testbench/ppicr_regs_chk.sv]
// Purpose: Port-level checks of the management register block
// Assumes: hready_in is tied to hreadyout_out
// Notes: Bus writes are shadowed here to predict gating and outputs
`timescale 1ns/100ps
module ppicr_regs_chk #(
  parameter TP_ONLY_PORT = 0,
  parameter MDIO_PULSE_CYCLES = 1
) (
  input wire mclk_in,
  input wire reset_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  input wire autoneg_enable_pin_in,
  input wire link_test_strap_pin_in,
  input wire scrambler_bypass_strap_pin_in,
  input wire fiber_select_strap_pin_in,
  input wire interrupt_output_n_out,
  input wire mdio_interrupt_pulse_out,
  input wire tx_test_enable_out,
  input wire loopback_data_disable_out,
  input wire sqe_enable_out,
  input wire jabber_disable_out,
  input wire link_test_disable_out,
  input wire scrambler_bypass_out,
  input wire fiber_select_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  wire take = hsel_in & hready_in & (htrans_in == 2'h2) &
              (haddr_in[31:7] == 25'h0);
  wire [4:0] idx = haddr_in[6:2];
  reg dp_wr_reg, en_reg, tst_reg, armed_reg, rd_is_reg, cfg_wr_reg;
  reg [4:0] dp_idx_reg;
  reg [15:0] cfg_reg;
  wire md = cfg_reg[12];
  wire [3:0] c10 = cfg_reg[11:8];
  wire [2:0] c100 = {cfg_reg[14], cfg_reg[3],
                     cfg_reg[2] & (TP_ONLY_PORT == 0)};

  always @(posedge mclk_in) begin
    if (reset_in) begin
      {dp_wr_reg, en_reg, tst_reg, armed_reg} <= 4'h0;
      {rd_is_reg, cfg_wr_reg, dp_idx_reg} <= 7'h00;
      cfg_reg <= 16'h0000;
    end else begin
      dp_wr_reg <= take & hwrite_in;
      dp_idx_reg <= idx;
      rd_is_reg <= take & ~hwrite_in & (idx == 5'h12);
      cfg_wr_reg <= dp_wr_reg & (dp_idx_reg == 5'h13);
      // Any interrupt status read disarms, not only one after a basic read
      if (take & ~hwrite_in & (idx == 5'h01))
        armed_reg <= 1'b1;
      else if (take & ~hwrite_in & (idx == 5'h12))
        armed_reg <= 1'b0;
      if (dp_wr_reg & (dp_idx_reg == 5'h11))
        {en_reg, tst_reg} <= hwdata_in[1:0];
      if (dp_wr_reg & (dp_idx_reg == 5'h13))
        cfg_reg <= hwdata_in[15:0];
    end
  end

  property p_set;
    en_reg && tst_reg |-> ##2 !interrupt_output_n_out;
  endproperty
  a_set: assert property (p_set) else $error("forced pin not low");
  property p_gate;
    $fell(interrupt_output_n_out) |-> $past(en_reg, 2);
  endproperty
  a_gate: assert property (p_gate) else $error("pin fell, gate off");
  // The line pulse rises with the flag, one edge ahead of the pin
  property p_md_fwd;
    $fell(interrupt_output_n_out) && $past(md, 2) && $past(en_reg, 2)
      |-> $past(mdio_interrupt_pulse_out);
  endproperty
  a_md_fwd: assert property (p_md_fwd) else $error("no line pulse");
  property p_md_only;
    $rose(mdio_interrupt_pulse_out) |-> $past(md) && $past(en_reg);
  endproperty
  a_md_only: assert property (p_md_only) else $error("stray pulse");
  property p_clear;
    $rose(interrupt_output_n_out) |-> $past(rd_is_reg) && $past(armed_reg, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("bad release");
  property p_cfg10;
    cfg_wr_reg |=> {loopback_data_disable_out, sqe_enable_out,
      jabber_disable_out, link_test_disable_out} == $past(c10);
  endproperty
  a_cfg10: assert property (p_cfg10) else $error("10M outs");
  property p_cfg100;
    cfg_wr_reg |=> {tx_test_enable_out, scrambler_bypass_out,
      fiber_select_out} == $past(c100);
  endproperty
  a_cfg100: assert property (p_cfg100) else $error("100M outs");
  property p_strap;
    $fell(reset_in) |-> ##3 link_test_disable_out ==
      (link_test_strap_pin_in & ~autoneg_enable_pin_in) &&
      scrambler_bypass_out == scrambler_bypass_strap_pin_in &&
      fiber_select_out == (fiber_select_strap_pin_in & (TP_ONLY_PORT == 0));
  endproperty
  a_strap: assert property (p_strap) else $error("strap reset");

  c_fall: cover property ($fell(interrupt_output_n_out));
  c_pulse: cover property ($rose(mdio_interrupt_pulse_out));
  c_free: cover property ($rose(interrupt_output_n_out));
endmodule // ppicr_regs_chk

bind ppicr_regs ppicr_regs_chk #(
  .TP_ONLY_PORT(TP_ONLY_PORT),
  .MDIO_PULSE_CYCLES(MDIO_PULSE_CYCLES)
) chk_u (
  .mclk_in(mclk_in), .reset_in(reset_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in),
  .autoneg_enable_pin_in(autoneg_enable_pin_in),
  .link_test_strap_pin_in(link_test_strap_pin_in),
  .scrambler_bypass_strap_pin_in(scrambler_bypass_strap_pin_in),
  .fiber_select_strap_pin_in(fiber_select_strap_pin_in),
  .interrupt_output_n_out(interrupt_output_n_out),
  .mdio_interrupt_pulse_out(mdio_interrupt_pulse_out),
  .tx_test_enable_out(tx_test_enable_out),
  .loopback_data_disable_out(loopback_data_disable_out),
  .sqe_enable_out(sqe_enable_out), .jabber_disable_out(jabber_disable_out),
  .link_test_disable_out(link_test_disable_out),
  .scrambler_bypass_out(scrambler_bypass_out),
  .fiber_select_out(fiber_select_out)
);

// [testbench/phy_port_interrupt_config_regs_test.sv]
// Purpose: Self-checking bench for the port management registers
// Assumes: Zero-wait slave, one transfer at a time
// Notes: Straps change only while reset is held
`timescale 1ns/100ps
module phy_port_interrupt_config_regs_test;
  logic mclk_in;
  logic reset_in = 1'b1;
  logic port_event_in = 1'b0;
  logic an_pin = 1'b0;
  logic lt_pin = 1'b1;
  logic scr_pin = 1'b1;
  logic fib_pin = 1'b0;
  logic [15:0] bstat = 16'h7a49;
  wire hsel, hwrite, hrdy, hresp, int_n, mdp, tx, lb, sqe, jab, ltd, scr, fib;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [15:0] cfg_view = {1'b0, tx, 2'b00, lb, sqe, jab, ltd, 4'h0, scr,
                          fib, 2'b00};
  int n_fail = 0;
  int num_checks = 0;
  int n_pulse = 0;

  ppicr_mac_model mac_u (.mclk_in(mclk_in), .hready_in(hrdy),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));
  ppicr_regs #(.TP_ONLY_PORT(0), .MDIO_PULSE_CYCLES(1)) dut_u (
    .mclk_in(mclk_in), .reset_in(reset_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .basic_status_in(bstat), .port_event_in(port_event_in),
    .autoneg_enable_pin_in(an_pin), .link_test_strap_pin_in(lt_pin),
    .scrambler_bypass_strap_pin_in(scr_pin),
    .fiber_select_strap_pin_in(fib_pin), .interrupt_output_n_out(int_n),
    .mdio_interrupt_pulse_out(mdp), .tx_test_enable_out(tx),
    .loopback_data_disable_out(lb), .sqe_enable_out(sqe),
    .jabber_disable_out(jab), .link_test_disable_out(ltd),
    .scrambler_bypass_out(scr), .fiber_select_out(fib));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (mdp === 1'b1) n_pulse <= n_pulse + 1;

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    logic [31:0] q;
    mac_u.xfer(1'b1, {25'h0, i, 2'b00}, d, q);
  endtask
  task automatic rd(input logic [4:0] i, output logic [31:0] q);
    mac_u.xfer(1'b0, {25'h0, i, 2'b00}, 32'h0, q);
  endtask
  task automatic event_pulse;
    @(posedge mclk_in) port_event_in <= 1'b1;
    @(posedge mclk_in) port_event_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic t_straps;
    logic [31:0] q;
    rd(5'h13, q);
    check("cfg_rst", q, 32'h0108);
    rd(5'h11, q);
    check("ie_rst", q, 32'h0);
    check("outs_rst", cfg_view, 16'h0108);
    // Second reset with autoneg, bypass and fiber straps flipped, link test strap kept, long enough to refill the sync
    @(posedge mclk_in) reset_in <= 1'b1;
    {an_pin, scr_pin, fib_pin} <= 3'b101;
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(5'h13, q);
    check("cfg_rst2", q, 32'h0004);
  endtask

  task automatic t_cfg;
    int bits[8] = '{14, 12, 11, 10, 9, 8, 3, 2};
    logic [31:0] q;
    foreach (bits[k]) begin
      wr(5'h13, 32'h1 << bits[k]);
      rd(5'h13, q);
      check("cfg_rd", q, 32'h1 << bits[k]);
      check("cfg_out", cfg_view, (16'h1 << bits[k]) & 16'h4f0c);
    end
  endtask

  task automatic t_ro;
    logic [31:0] q;
    wr(5'h12, 32'hffff);
    rd(5'h12, q);
    check("stat_ro", q, 32'h0);
    wr(5'h01, 32'hffff);
    rd(5'h01, q);
    check("basic_ro", q, {16'h0, bstat});
    wr(5'h10, 32'hffff);
    rd(5'h10, q);
    check("hole", q, 32'h0);
    mac_u.xfer(1'b0, 32'h80, 32'h0, q);
    check("high", q, 32'h0);
    check("resp", {hrdy, hresp}, 2'b10);
  endtask

  task automatic t_gate;
    logic [31:0] q;
    wr(5'h13, 32'h1000);
    wr(5'h11, 32'h1);
    event_pulse();
    check("gate_pin", int_n, 1'b1);
    check("gate_line", n_pulse, 0);
    rd(5'h12, q);
    check("gate_pend", q, 32'h0);
  endtask

  task automatic t_int;
    logic [31:0] q;
    int p0;
    p0 = n_pulse;
    wr(5'h11, 32'h3);
    repeat (3) @(posedge mclk_in);
    check("pin_set", int_n, 1'b0);
    check("line_pulse", n_pulse - p0, 1);
    rd(5'h12, q);
    check("pend_set", q, 32'h8000);
    wr(5'h11, 32'h2);
    repeat (3) @(posedge mclk_in);
    check("pin_hold", int_n, 1'b0);
    rd(5'h01, q);
    rd(5'h12, q);
    check("pend_rd", q, 32'h8000);
    repeat (2) @(posedge mclk_in);
    check("pin_free", int_n, 1'b1);
    rd(5'h12, q);
    check("pend_clr", q, 32'h0);
  endtask

  task automatic t_event;
    logic [31:0] q;
    int p0;
    wr(5'h13, 32'h0);
    p0 = n_pulse;
    event_pulse();
    check("ev_pin", int_n, 1'b0);
    check("ev_line", n_pulse - p0, 0);
    rd(5'h01, q);
    rd(5'h12, q);
    repeat (2) @(posedge mclk_in);
    check("ev_free", int_n, 1'b1);
    wr(5'h11, 32'h0);
    event_pulse();
    check("ev_gate", int_n, 1'b1);
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_straps();
    t_cfg();
    t_ro();
    t_gate();
    t_int();
    t_event();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_fail++;
    tally_and_finish();
  end
endmodule // phy_port_interrupt_config_regs_test
